// ---- rtl/rxcse_status_encoder.sv ----
// rxcse_status_encoder: per-character receive status word and data output
// assumes: one decoded character per char_valid cycle from the decoder,
// condition flags valid beside it, host samples the registered output bus
//
// Operation
// - valid data character reports 000, level 7
// - other valid special character reports 001, level 7
// - type A buffer add/drop failure reports 010
// - framing match reports 011, data kept unless a disparity error puts C4.7/C1.7/C2.7 on it
// - undecodable character: C0.7 and 100
// - receive PLL unlocked reports 101, level 1
// - disparity error: C4.7/C1.7/C2.7 and 110
// - bist data match reports 000
// - bist command match reports 001
// - bist last character valid reports 010
// - bist last character invalid reports 100
// - bist start, unlock, buffer fault report 101
// - bist compare mismatch reports 110
// - bist waiting for start character reports 111
// - status type control register bit picks format A or B
// - PLL unlock forces bist to start state
// - errors over matches by more than 16 forces wait
// - buffer fault holds bist start nine characters
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "rxcse_map.svh"

module rxcse_status_encoder (
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // decoder side, one character per char_valid
  input wire logic char_valid,
  input wire logic [7:0] decoded_byte,
  input wire logic is_special,
  input wire logic framing_match,
  input wire logic code_violation,
  input wire logic disparity_error,
  input wire logic [1:0] disparity_kind,
  input wire logic elastic_fault,
  input wire logic pll_unlocked,
  // bist comparator side
  input wire logic bist_match,
  input wire logic bist_start_char,
  input wire logic bist_last_char,
  // framer steering
  output logic [1:0] framing_char_select,
  // host output bus
  output logic [7:0] rx_data,
  output logic [2:0] rx_char_status,
  output logic rx_char_valid
);

  // control register and read path
  logic [31:0] ctrl; // software configuration
  logic [31:0] next_ctrl;
  logic [31:0] next_rdata;
  logic bist_en; // receive bist compare enabled
  logic status_type_select; // low: type A, high: type B

  // bist state
  rxcse_pkg::rxcse_bist_state_t bist_state;
  rxcse_pkg::rxcse_bist_state_t next_bist_state;
  logic [3:0] hold_cnt; // characters left until buffer recentred
  logic [3:0] next_hold_cnt;
  logic signed [15:0] balance; // errors minus matches
  logic signed [15:0] next_balance;

  // output register
  logic [7:0] next_rx_data;
  logic [2:0] next_rx_char_status;
  logic next_rx_char_valid;

  // normal-format priority pick
  logic [7:1] prio_req;
  logic [2:0] prio_level;

  assign bist_en = ctrl[`RXCSE_CTRL_BIST_BIT];
  assign status_type_select = ctrl[`RXCSE_CTRL_TYPE_BIT];
  assign framing_char_select = ctrl[`RXCSE_CTRL_FRAME_LSB +: 2];

  // register writes and read data, answered one cycle after the strobe
  always_comb begin
    next_ctrl = ctrl;
    next_rdata = 32'h0000_0000;
    if (bus_wr && bus_addr == `RXCSE_ADDR_CTRL) begin
      next_ctrl = {28'h0000000, bus_wdata[3:0]}; // upper bits reserved
    end
    if (bus_rd) begin
      if (bus_addr == `RXCSE_ADDR_CTRL) begin
        next_rdata = ctrl;
      end else if (bus_addr == `RXCSE_ADDR_STATUS) begin
        next_rdata[`RXCSE_STAT_CODE_LSB +: 3] = rx_char_status;
        next_rdata[`RXCSE_STAT_STATE_LSB +: 2] = bist_state;
        next_rdata[`RXCSE_STAT_HOLD_LSB +: 4] = hold_cnt;
      end else if (bus_addr == `RXCSE_ADDR_BALANCE) begin
        next_rdata = {{16{balance[15]}}, balance};
      end else begin
        next_rdata = 32'h0000_0000; // unmapped reads as zero
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `RXCSE_CTRL_RESET;
      bus_rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      bus_rdata <= next_rdata;
    end
  end

  // requests by priority level; type B leaves the buffer code reserved
  always_comb begin
    prio_req = 7'h00;
    prio_req[`RXCSE_LVL_UNLOCK] = pll_unlocked;
    prio_req[`RXCSE_LVL_ELASTIC] = elastic_fault && !status_type_select;
    prio_req[`RXCSE_LVL_CODEVIOL] = code_violation;
    prio_req[`RXCSE_LVL_FRAMING] = framing_match;
    prio_req[`RXCSE_LVL_DISPARITY] = disparity_error;
    prio_req[`RXCSE_LVL_CHAR] = 1'b1;
  end

  rxcse_prio_pick u_pick (
    .req(prio_req),
    .level(prio_level)
  );

  // bist progress and status, next values
  always_comb begin
    next_bist_state = bist_state;
    next_hold_cnt = hold_cnt;
    next_balance = balance;
    next_rx_char_status = rx_char_status;
    next_rx_data = rx_data;
    next_rx_char_valid = char_valid;
    if (char_valid) begin
      // data bus substitution for violations
      if (code_violation) begin
        next_rx_data = `RXCSE_CHAR_C0_7;
      end else if (disparity_error) begin
        if (disparity_kind == `RXCSE_DISP_C1) begin
          next_rx_data = `RXCSE_CHAR_C1_7;
        end else if (disparity_kind == `RXCSE_DISP_C2) begin
          next_rx_data = `RXCSE_CHAR_C2_7;
        end else begin
          next_rx_data = `RXCSE_CHAR_C4_7;
        end
      end else begin
        next_rx_data = decoded_byte; // framing keeps its value
      end
      // normal formats
      case (prio_level)
        `RXCSE_LVL_UNLOCK: next_rx_char_status = `RXCSE_ST_UNLOCK;
        `RXCSE_LVL_ELASTIC: next_rx_char_status = `RXCSE_ST_ELASTIC;
        `RXCSE_LVL_CODEVIOL: next_rx_char_status = `RXCSE_ST_CODEVIOL;
        `RXCSE_LVL_FRAMING: next_rx_char_status = `RXCSE_ST_FRAMING;
        `RXCSE_LVL_DISPARITY: next_rx_char_status = `RXCSE_ST_DISPARITY;
        default: next_rx_char_status = is_special ? `RXCSE_ST_SPECIAL : `RXCSE_ST_DATA;
      endcase
      // bist countdown only counts characters, not clocks
      if (hold_cnt != 4'h0) begin
        next_hold_cnt = hold_cnt - 4'h1;
      end
      if (bist_en) begin
        if (pll_unlocked) begin
          // unlock wins over every state
          next_bist_state = rxcse_pkg::RXCSE_BIST_START;
          next_rx_char_status = `RXCSE_ST_UNLOCK;
          // a buffer fault beside the unlock still needs its recentre hold
          if (elastic_fault) begin
            next_hold_cnt = `RXCSE_RECENTRE_CHARS;
          end
        end else if (elastic_fault || hold_cnt != 4'h0) begin
          // hold start until the buffer is centred again
          if (elastic_fault) begin
            next_hold_cnt = `RXCSE_RECENTRE_CHARS;
          end
          next_bist_state = rxcse_pkg::RXCSE_BIST_START;
          next_rx_char_status = `RXCSE_ST_UNLOCK;
        end else begin
          case (bist_state)
            rxcse_pkg::RXCSE_BIST_START: begin
              // compares not begun; next character starts the search
              next_rx_char_status = `RXCSE_ST_UNLOCK;
              next_bist_state = rxcse_pkg::RXCSE_BIST_WAIT;
            end
            rxcse_pkg::RXCSE_BIST_WAIT: begin
              next_rx_char_status = `RXCSE_ST_BIST_WAIT;
              if (bist_start_char) begin
                next_bist_state = rxcse_pkg::RXCSE_BIST_COMPARE;
                next_balance = 16'sh0000;
              end
            end
            rxcse_pkg::RXCSE_BIST_COMPARE: begin
              if (bist_last_char) begin
                next_rx_char_status = bist_match ? `RXCSE_ST_ELASTIC : `RXCSE_ST_CODEVIOL;
              end else if (bist_match) begin
                next_rx_char_status = is_special ? `RXCSE_ST_SPECIAL : `RXCSE_ST_DATA;
              end else begin
                next_rx_char_status = `RXCSE_ST_DISPARITY;
              end
              // balance saturates low so a long good run cannot wrap
              if (!bist_match) begin
                next_balance = balance + 16'sh0001;
              end else if (balance != `RXCSE_BAL_MIN) begin
                next_balance = balance - 16'sh0001;
              end
              if (next_balance > `RXCSE_ERR_EXCESS) begin
                next_bist_state = rxcse_pkg::RXCSE_BIST_WAIT;
              end
            end
            default: next_bist_state = rxcse_pkg::RXCSE_BIST_START;
          endcase
        end
      end else begin
        // bist off: rearm at start for the next enable
        next_bist_state = rxcse_pkg::RXCSE_BIST_START;
      end
    end
  end

  // bist and output registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bist_state <= rxcse_pkg::RXCSE_BIST_START;
      hold_cnt <= 4'h0;
      balance <= 16'sh0000;
      rx_data <= 8'h00;
      rx_char_status <= 3'h0;
      rx_char_valid <= 1'b0;
    end else begin
      bist_state <= next_bist_state;
      hold_cnt <= next_hold_cnt;
      balance <= next_balance;
      rx_data <= next_rx_data;
      rx_char_status <= next_rx_char_status;
      rx_char_valid <= next_rx_char_valid;
    end
  end

  // checks on the status word
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_unlock_normal: assert property (
    char_valid && !bist_en && pll_unlocked |=> rx_char_valid && rx_char_status == 3'h5)
    else $error("unlock not reported as 101");

  chk_plain_data: assert property (
    char_valid && !bist_en && !pll_unlocked && !(elastic_fault && !status_type_select)
      && !code_violation && !framing_match && !disparity_error && !is_special
      |=> rx_char_status == 3'h0 && rx_data == $past(decoded_byte))
    else $error("plain data character not reported as 000");

  chk_special_code: assert property (
    char_valid && !bist_en && !pll_unlocked && !(elastic_fault && !status_type_select)
      && !code_violation && !framing_match && !disparity_error && is_special
      |=> rx_char_status == 3'h1)
    else $error("special character not reported as 001");

  chk_elastic_type: assert property (
    char_valid && !bist_en && !pll_unlocked && elastic_fault
      |=> (rx_char_status == 3'h2) == !$past(status_type_select))
    else $error("buffer fault code wrong for status type");

  chk_framing_char: assert property (
    char_valid && !bist_en && !pll_unlocked && !elastic_fault && !code_violation && framing_match
      |=> rx_char_status == 3'h3 && rx_data == $past(decoded_byte))
    else $error("framing match not reported as 011");

  chk_code_viol: assert property (
    char_valid && !bist_en && !pll_unlocked && !elastic_fault && code_violation
      |=> rx_char_status == 3'h4 && rx_data == 8'he0)
    else $error("code violation not reported as 100 with C0.7");

  chk_disparity_err: assert property (
    char_valid && !bist_en && !pll_unlocked && !elastic_fault && !code_violation
      && !framing_match && disparity_error
      |=> rx_char_status == 3'h6 && (rx_data == 8'he1 || rx_data == 8'he2 || rx_data == 8'he4))
    else $error("disparity error not reported as 110");

  chk_bist_unlock: assert property (
    char_valid && bist_en && pll_unlocked
      |=> bist_state == rxcse_pkg::RXCSE_BIST_START && rx_char_status == 3'h5)
    else $error("unlock did not force bist start");

  chk_bist_recentre: assert property (
    bist_en && char_valid && elastic_fault |=> hold_cnt == 4'h9 ##0 rx_char_status == 3'h5)
    else $error("buffer fault did not hold bist start");

  chk_bist_wait: assert property (
    char_valid && bist_en && !pll_unlocked && !elastic_fault && hold_cnt == 4'h0
      && bist_state == rxcse_pkg::RXCSE_BIST_WAIT |=> rx_char_status == 3'h7)
    else $error("bist wait not reported as 111");

endmodule : rxcse_status_encoder

`default_nettype wire

// ---- include/rxcse_map.svh ----
// rxcse_map.svh: offsets, fields, status codes and counts for the receive status encoder
// assumes: included by bare name from the encoder design file and the testbench
`ifndef RXCSE_MAP_SVH
`define RXCSE_MAP_SVH

// register byte addresses on the plain register port
`define RXCSE_ADDR_CTRL 8'h00
`define RXCSE_ADDR_STATUS 8'h04
`define RXCSE_ADDR_BALANCE 8'h08

// control register fields
`define RXCSE_CTRL_BIST_BIT 0
`define RXCSE_CTRL_TYPE_BIT 1
`define RXCSE_CTRL_FRAME_LSB 2
`define RXCSE_CTRL_RESET 32'h0000_0000

// status register fields
`define RXCSE_STAT_CODE_LSB 0
`define RXCSE_STAT_STATE_LSB 4
`define RXCSE_STAT_HOLD_LSB 8

// three-bit status codes
`define RXCSE_ST_DATA 3'h0
`define RXCSE_ST_SPECIAL 3'h1
`define RXCSE_ST_ELASTIC 3'h2
`define RXCSE_ST_FRAMING 3'h3
`define RXCSE_ST_CODEVIOL 3'h4
`define RXCSE_ST_UNLOCK 3'h5
`define RXCSE_ST_DISPARITY 3'h6
`define RXCSE_ST_BIST_WAIT 3'h7

// priority levels, 1 most important
`define RXCSE_LVL_UNLOCK 3'h1
`define RXCSE_LVL_ELASTIC 3'h2
`define RXCSE_LVL_CODEVIOL 3'h4
`define RXCSE_LVL_FRAMING 3'h5
`define RXCSE_LVL_DISPARITY 3'h6
`define RXCSE_LVL_CHAR 3'h7

// substituted characters on the data bus
`define RXCSE_CHAR_C0_7 8'he0
`define RXCSE_CHAR_C1_7 8'he1
`define RXCSE_CHAR_C2_7 8'he2
`define RXCSE_CHAR_C4_7 8'he4

// disparity error kind selector
`define RXCSE_DISP_C1 2'h0
`define RXCSE_DISP_C2 2'h1

// bist counts
`define RXCSE_RECENTRE_CHARS 4'h9
`define RXCSE_ERR_EXCESS 16'sh0010
`define RXCSE_BAL_MIN 16'sh8001

`endif

// ---- include/rxcse_pkg.sv ----
// rxcse_pkg: types of the receive status encoder
// assumes: nothing beyond the tool's package support
package rxcse_pkg;

  // receive bist progress
  typedef enum logic [1:0] {
    RXCSE_BIST_START = 2'b00,
    RXCSE_BIST_WAIT = 2'b01,
    RXCSE_BIST_COMPARE = 2'b10
  } rxcse_bist_state_t;

endpackage : rxcse_pkg

// ---- rtl/rxcse_prio_pick.sv ----
// rxcse_prio_pick: picks the most important asserted priority level
// assumes: level 1 is most important, level 7 always requested by the caller
`timescale 1ns/1ps
`default_nettype none

module rxcse_prio_pick (
  input wire logic [7:1] req,
  output logic [2:0] level
);

  // scan from least to most important so the lowest level wins
  always_comb begin
    level = 3'h7;
    for (int i = 7; i >= 1; i--) begin
      if (req[i]) begin
        level = 3'(i);
      end
    end
  end

endmodule : rxcse_prio_pick

`default_nettype wire

// ---- test/rxcse_host_model.sv ----
// rxcse_host_model: host logic that samples the receive output bus
// assumes: same clock as the encoder, one character per rx_char_valid cycle
`timescale 1ns/1ps
`default_nettype none

module rxcse_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] rx_data,
  input wire logic [2:0] rx_char_status,
  input wire logic rx_char_valid,
  output logic [7:0] got_data,
  output logic [2:0] got_status,
  output logic [15:0] got_count
);
  // one clock feeds both link ends, so clock selection always agrees
  // capture data and status together; a held valid shows up as an extra count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      got_data <= 8'h00;
      got_status <= 3'h0;
      got_count <= 16'h0000;
    end else if (rx_char_valid) begin
      got_data <= rx_data;
      got_status <= rx_char_status;
      got_count <= got_count + 16'h0001;
    end
  end
endmodule : rxcse_host_model

`default_nettype wire

// ---- test/tb_rx_char_status_encoder.sv ----
// tb_rx_char_status_encoder: self-checking bench for the receive status encoder
// assumes: flags and register strobes driven by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
`include "rxcse_map.svh"

module tb_rx_char_status_encoder;
  logic clk, sys_rst, bus_wr, bus_rd, char_valid, is_special, framing_match;
  logic code_violation, disparity_error, elastic_fault, pll_unlocked;
  logic bist_match, bist_start_char, bist_last_char, rx_char_valid;
  logic [7:0] bus_addr, decoded_byte, rx_data, got_data;
  logic [31:0] bus_wdata, bus_rdata;
  logic [1:0] disparity_kind, framing_char_select;
  logic [2:0] rx_char_status, got_status;
  logic [15:0] got_count;
  int n_fail, checks_done, cycles;
  // row: {flags 12, byte 8, expected data 8, expected status 3}
  // flags: 11 type b, 10 special, 9 framing, 8 code viol, 7 disparity, 5:4 kind, 3 buffer, 2 unlock
  logic [30:0] rows [0:14];

  rxcse_status_encoder u_rxcse_status_encoder (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .char_valid(char_valid), .decoded_byte(decoded_byte), .is_special(is_special),
    .framing_match(framing_match), .code_violation(code_violation), .disparity_error(disparity_error),
    .disparity_kind(disparity_kind), .elastic_fault(elastic_fault), .pll_unlocked(pll_unlocked),
    .bist_match(bist_match), .bist_start_char(bist_start_char), .bist_last_char(bist_last_char),
    .framing_char_select(framing_char_select), .rx_data(rx_data), .rx_char_status(rx_char_status),
    .rx_char_valid(rx_char_valid));

  rxcse_host_model u_rxcse_host_model (.clk(clk), .sys_rst(sys_rst), .rx_data(rx_data),
    .rx_char_status(rx_char_status), .rx_char_valid(rx_char_valid), .got_data(got_data),
    .got_status(got_status), .got_count(got_count));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : bus_write

  // read data stands only in the cycle after the strobe
  task automatic bus_read(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    check(bus_rdata & mask, exp);
  endtask : bus_read

  // one character in, then compare what the host captured
  task automatic send(input logic [11:0] f, input logic [7:0] b, input logic [2:0] bst,
                      input logic [7:0] ed, input logic [2:0] es);
    logic [15:0] cnt;
    cnt = got_count;
    @(posedge clk);
    char_valid <= 1'b1;
    decoded_byte <= b;
    is_special <= f[10];
    framing_match <= f[9];
    code_violation <= f[8];
    disparity_error <= f[7];
    disparity_kind <= f[5:4];
    elastic_fault <= f[3];
    pll_unlocked <= f[2];
    bist_match <= bst[2];
    bist_start_char <= bst[1];
    bist_last_char <= bst[0];
    @(posedge clk);
    char_valid <= 1'b0;
    @(posedge clk);
    #1;
    check({24'h000000, got_data}, {24'h000000, ed});
    check({29'h00000000, got_status}, {29'h00000000, es});
    // exactly one valid cycle per character
    check({16'h0000, got_count}, {16'h0000, cnt + 16'h0001});
  endtask : send

  initial begin
    rows[0] = {12'h000, 8'h5a, 8'h5a, 3'h0};
    rows[1] = {12'h400, 8'hbc, 8'hbc, 3'h1};
    rows[2] = {12'h600, 8'hbc, 8'hbc, 3'h3};
    rows[3] = {12'h100, 8'h5a, 8'he0, 3'h4};
    rows[4] = {12'h180, 8'h5a, 8'he0, 3'h4};
    rows[5] = {12'h080, 8'h5a, 8'he1, 3'h6};
    rows[6] = {12'h090, 8'h5a, 8'he2, 3'h6};
    rows[7] = {12'h0a0, 8'h5a, 8'he4, 3'h6};
    rows[8] = {12'h0b0, 8'h5a, 8'he4, 3'h6};
    rows[9] = {12'h008, 8'h5a, 8'h5a, 3'h2};
    rows[10] = {12'h808, 8'h5a, 8'h5a, 3'h0};
    rows[11] = {12'h108, 8'h5a, 8'he0, 3'h2};
    rows[12] = {12'h004, 8'h5a, 8'h5a, 3'h5};
    rows[13] = {12'h10c, 8'h5a, 8'he0, 3'h5};
    rows[14] = {12'h900, 8'h5a, 8'he0, 3'h4};
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    sys_rst = 1'b1;
    {bus_wr, bus_rd, char_valid, is_special, framing_match, code_violation} = 6'h00;
    {disparity_error, elastic_fault, pll_unlocked, bist_match, bist_start_char, bist_last_char} = 6'h00;
    bus_addr = 8'h00;
    bus_wdata = 32'h00000000;
    decoded_byte = 8'h00;
    disparity_kind = 2'h0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    // control register: reset value, unused bits, framing steering, unmapped place
    bus_read(`RXCSE_ADDR_CTRL, 32'hffffffff, `RXCSE_CTRL_RESET);
    bus_write(`RXCSE_ADDR_CTRL, 32'hfffffffc);
    bus_read(`RXCSE_ADDR_CTRL, 32'hffffffff, 32'h0000000c);
    // read data stands one cycle only, then drops back to zero
    @(posedge clk);
    #1;
    check(bus_rdata, 32'h00000000);
    check({30'h00000000, framing_char_select}, 32'h00000003);
    bus_read(8'h0c, 32'hffffffff, 32'h00000000);
    // normal formats, status type taken from each row
    for (int i = 0; i < 15; i++) begin
      bus_write(`RXCSE_ADDR_CTRL, {30'h00000000, rows[i][30], 1'b0});
      send(rows[i][30:19], rows[i][18:11], 3'h0, rows[i][10:3], rows[i][2:0]);
    end
    // bist walk through start, wait and compare
    bus_write(`RXCSE_ADDR_CTRL, 32'h00000001);
    send(12'h000, 8'h11, 3'h0, 8'h11, 3'h5);
    send(12'h000, 8'h11, 3'h0, 8'h11, 3'h7);
    send(12'h000, 8'h00, 3'h2, 8'h00, 3'h7);
    send(12'h000, 8'h22, 3'h4, 8'h22, 3'h0);
    send(12'h400, 8'hbc, 3'h4, 8'hbc, 3'h1);
    send(12'h000, 8'h33, 3'h0, 8'h33, 3'h6);
    send(12'h000, 8'h44, 3'h5, 8'h44, 3'h2);
    send(12'h000, 8'h44, 3'h1, 8'h44, 3'h4);
    // lock loss drops back to start from compare
    send(12'h004, 8'h55, 3'h0, 8'h55, 3'h5);
    send(12'h000, 8'h55, 3'h0, 8'h55, 3'h5);
    send(12'h000, 8'h55, 3'h0, 8'h55, 3'h7);
    // errors ahead of matches by 17 fall back to wait, 16 do not
    send(12'h000, 8'h00, 3'h2, 8'h00, 3'h7);
    for (int i = 0; i < 17; i++) send(12'h000, 8'h66, 3'h0, 8'h66, 3'h6);
    send(12'h000, 8'h66, 3'h0, 8'h66, 3'h7);
    bus_read(`RXCSE_ADDR_STATUS, 32'h00000030, 32'h00000010);
    bus_read(`RXCSE_ADDR_BALANCE, 32'hffffffff, 32'h00000011);
    // buffer fault holds start while the buffer recentres
    send(12'h000, 8'h00, 3'h2, 8'h00, 3'h7);
    send(12'h008, 8'h77, 3'h4, 8'h77, 3'h5);
    for (int i = 0; i < 9; i++) send(12'h000, 8'h77, 3'h4, 8'h77, 3'h5);
    send(12'h000, 8'h77, 3'h4, 8'h77, 3'h5);
    send(12'h000, 8'h77, 3'h4, 8'h77, 3'h7);
    // back to the normal format
    bus_write(`RXCSE_ADDR_CTRL, 32'h00000000);
    send(12'h000, 8'h88, 3'h0, 8'h88, 3'h0);
    // mid-run reset clears the output bus and bist progress
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check({20'h00000, rx_char_valid, rx_data, rx_char_status}, 32'h00000000);
    bus_read(`RXCSE_ADDR_STATUS, 32'hffffffff, 32'h00000000);
    send(12'h000, 8'h99, 3'h0, 8'h99, 3'h0);
    give_verdict();
  end
endmodule : tb_rx_char_status_encoder

`default_nettype wire
